// ### mac_stat_consts.vh
`ifndef MAC_STAT_CONSTS_VH
`define MAC_STAT_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EXCESSIVE_COLLISION_COUNT_OFS 12'h140
`define RECEIVE_SYMBOL_ERROR_COUNT_OFS 12'h198
`define NETWORK_CONFIGURATION_OFS 12'h000
`define EVENT_STATUS_OFS 12'h004
`define EVENT_MASK_OFS 12'h008
`define FCS_ALIGN_COUNT_OFS 12'h010
`define JABBER_COUNT_OFS 12'h014

// ----------------------------------------
// Fields and values
// ----------------------------------------
`define TALLY_WIDTH 10
`define TALLY_RESET 10'h000
`define EXT_MAX_FRAME_BIT 0
`define EXCESS_COLLISION_LIMIT 5'h10
`define MIN_FRAME_BYTES 14'h0040
`define MAX_FRAME_BYTES 14'h05EE
`define EXT_MAX_FRAME_BYTES 14'h0600
`define EVENT_COUNT 4
`define EV_EXCESSIVE_COLLISION_TALLY 0
`define EV_SYMERR 1
`define EV_FCSALIGN 2
`define EV_JABBER 3

`endif

// ### event_tally.v
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Saturation-free wrapping event counter
// ----------------------------------------
module event_tally #(
  parameter WIDTH = 10
) (
  input wire clk,
  input wire rst,
  input wire bump,
  output reg [WIDTH-1:0] count_r
);

  // The count wraps at its width, like a plain binary statistics counter.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= {WIDTH{1'b0}};
    end else if (bump) begin
      count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // event_tally

`default_nettype wire

// ### mac_error_statistics_counters.v
// What this block does
// - Count once each frame abandoned after 16 transmit collisions.
// - Count once each received frame with PHY receive error seen.
// - At 10/100 count symbol errors regardless of frame length checks.
// - Symbol-error frames of 64 to 1518 bytes also count as FCS/alignment errors.
// - Extended max frame size setting raises that upper bound to 1536 bytes.
// - Symbol-error frames longer than the maximum count as jabber errors.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "mac_stat_consts.vh"

module mac_error_statistics_counters (
  input wire clk,
  input wire rst,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  input wire txAbort,
  input wire [4:0] txCollisionCount,
  input wire rxFrameActive,
  input wire phy_receive_error,
  input wire rxFrameEnd,
  input wire [13:0] rxFrameBytes,
  output reg irq_r
);

  // ----------------------------------------
  // Frame error tracking
  // ----------------------------------------
  reg symErrSeen_r;
  reg [`EVENT_COUNT-1:0] evStatus_r;
  reg [`EVENT_COUNT-1:0] evMask_r;
  reg network_configuration_r;
  wire [`TALLY_WIDTH-1:0] excessive_collision_tally;
  wire [`TALLY_WIDTH-1:0] symbol_error_tally;
  wire [`TALLY_WIDTH-1:0] fcsAlignTally;
  wire [`TALLY_WIDTH-1:0] jabberTally;
  wire [13:0] upperBound;
  wire frameHadError;
  wire xcolEvent;
  wire symEvent;
  wire fcsEvent;
  wire jabEvent;
  wire [`EVENT_COUNT-1:0] events;
  wire busReq;
  wire [11:0] ofs;
  wire extended_max_frame_size;

  assign extended_max_frame_size = network_configuration_r;

  assign xcolEvent = txAbort && (txCollisionCount == `EXCESS_COLLISION_LIMIT);

  // An error flagged in the closing cycle still belongs to that frame.
  assign frameHadError = symErrSeen_r || (rxFrameActive && phy_receive_error);

  assign symEvent = rxFrameEnd && frameHadError;

  assign upperBound = extended_max_frame_size ? `EXT_MAX_FRAME_BYTES : `MAX_FRAME_BYTES;

  assign fcsEvent = symEvent && (rxFrameBytes >= `MIN_FRAME_BYTES) &&
                    (rxFrameBytes <= upperBound);

  assign jabEvent = symEvent && (rxFrameBytes > upperBound);

  assign events = {jabEvent, fcsEvent, symEvent, xcolEvent};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      symErrSeen_r <= 1'b0;
    end else if (rxFrameEnd) begin
      symErrSeen_r <= 1'b0;
    end else if (rxFrameActive && phy_receive_error) begin
      symErrSeen_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  // tally bump
  event_tally #(.WIDTH(`TALLY_WIDTH)) xcolTally (
    .clk(clk),
    .rst(rst),
    .bump(xcolEvent),
    .count_r(excessive_collision_tally)
  );

  event_tally #(.WIDTH(`TALLY_WIDTH)) symTally (
    .clk(clk),
    .rst(rst),
    .bump(symEvent),
    .count_r(symbol_error_tally)
  );

  event_tally #(.WIDTH(`TALLY_WIDTH)) fcsTally (
    .clk(clk),
    .rst(rst),
    .bump(fcsEvent),
    .count_r(fcsAlignTally)
  );

  event_tally #(.WIDTH(`TALLY_WIDTH)) jabTally (
    .clk(clk),
    .rst(rst),
    .bump(jabEvent),
    .count_r(jabberTally)
  );

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign ofs = wb_adr_i[11:0];

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `EXCESSIVE_COLLISION_COUNT_OFS) ||
               (a == `RECEIVE_SYMBOL_ERROR_COUNT_OFS) ||
               (a == `NETWORK_CONFIGURATION_OFS) ||
               (a == `EVENT_STATUS_OFS) || (a == `EVENT_MASK_OFS) ||
               (a == `FCS_ALIGN_COUNT_OFS) || (a == `JABBER_COUNT_OFS);
    end
  endfunction

  // Answer one cycle after the request; an unmapped word gets err instead.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq && (wb_adr_i[31:12] == 20'h00000) && mapped(ofs);
      wb_err_o <= busReq && !((wb_adr_i[31:12] == 20'h00000) && mapped(ofs));
      wb_dat_o <= 32'h00000000;
      if (busReq && !wb_we_i) begin
        case (ofs)
          `EXCESSIVE_COLLISION_COUNT_OFS: wb_dat_o <= {22'h000000, excessive_collision_tally};
          `RECEIVE_SYMBOL_ERROR_COUNT_OFS: wb_dat_o <= {22'h000000, symbol_error_tally};
          `FCS_ALIGN_COUNT_OFS: wb_dat_o <= {22'h000000, fcsAlignTally};
          `JABBER_COUNT_OFS: wb_dat_o <= {22'h000000, jabberTally};
          `NETWORK_CONFIGURATION_OFS: wb_dat_o <= {31'h00000000, network_configuration_r};
          `EVENT_STATUS_OFS: wb_dat_o <= {28'h0000000, evStatus_r};
          `EVENT_MASK_OFS: wb_dat_o <= {28'h0000000, evMask_r};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Control registers; counter offsets take no write at all.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      network_configuration_r <= 1'b0;
      evMask_r <= 4'h0;
    end else if (busReq && wb_we_i && wb_sel_i[0]) begin
      if (ofs == `NETWORK_CONFIGURATION_OFS) begin
        network_configuration_r <= wb_dat_i[`EXT_MAX_FRAME_BIT];
      end
      if (ofs == `EVENT_MASK_OFS) begin
        evMask_r <= wb_dat_i[3:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // A new event in the same cycle as a write-one clear keeps its bit set.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      evStatus_r <= 4'h0;
    end else if (busReq && wb_we_i && wb_sel_i[0] && ofs == `EVENT_STATUS_OFS) begin
      evStatus_r <= (evStatus_r & ~wb_dat_i[3:0]) | events;
    end else begin
      evStatus_r <= evStatus_r | events;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evStatus_r & evMask_r);
    end
  end

endmodule // mac_error_statistics_counters

`default_nettype wire

// ### mac_stat_chk.sv
`timescale 1ns/10ps
`default_nettype none
module mac_stat_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic txAbort,
  input wire logic [4:0] txCollisionCount,
  input wire logic irq_r
);
  logic [9:0] excessive_collision_tally_r;
  always_ff @(posedge clk or posedge rst)
    if (rst) excessive_collision_tally_r <= 10'h000;
    else if (txAbort && txCollisionCount == 5'h10) excessive_collision_tally_r <= excessive_collision_tally_r + 10'h001;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence rdAck(a);
    wb_ack_o && !wb_we_i && wb_adr_i[11:0] == a;
  endsequence
  a_ack_answer: assert property (req |=> wb_ack_o || wb_err_o)
    else $error("request not answered");
  a_unmapped_err: assert property (req and wb_adr_i[11:0] == 12'h020 |=> wb_err_o)
    else $error("unmapped access not refused");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_resp_excl: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_read_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_upper_zero: assert property (rdAck(12'h198) |-> wb_dat_o[31:10] == 22'h0)
    else $error("upper bits not zero");
  a_excessive_collision_tally_read: assert property (rdAck(12'h140) |-> wb_dat_o[9:0] == $past(excessive_collision_tally_r))
    else $error("collision tally wrong");
  a_reset_quiet: assert property ($fell(rst) |-> !wb_ack_o && !irq_r)
    else $error("outputs busy after reset");
endmodule // mac_stat_chk
bind mac_error_statistics_counters mac_stat_chk chk_u (.clk(clk), .rst(rst),
  .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .txAbort(txAbort),
  .txCollisionCount(txCollisionCount), .irq_r(irq_r));
`default_nettype wire

// ### phy_line_model.sv
`timescale 1ns/10ps
`default_nettype none
module phy_line_model (
  input wire logic clk,
  output logic ab,
  output logic [4:0] cc,
  output logic act,
  output logic rxe,
  output logic fe,
  output logic [13:0] fb
);
  initial {ab, cc, act, rxe, fe, fb} = '0;
  task automatic abortTx(input logic [4:0] col);
    @(posedge clk);
    ab <= 1'b1;
    cc <= col;
    @(posedge clk);
    ab <= 1'b0;
    cc <= ~col;
  endtask
  // The length is only valid in the end cycle, so it shows garbage otherwise.
  task automatic recv(input logic [13:0] len, input logic bad, input int dly);
    @(posedge clk);
    act <= 1'b1;
    repeat (dly) @(posedge clk);
    rxe <= bad;
    @(posedge clk);
    fe <= 1'b1;
    fb <= len;
    @(posedge clk);
    {act, rxe, fe} <= 3'h0;
    fb <= ~len;
  endtask
endmodule // phy_line_model
`default_nettype wire

// ### mac_error_statistics_counters_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin errorCnt++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module mac_error_statistics_counters_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] adr = 32'h0;
  logic [31:0] wd = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] rd;
  logic ack, err, irq, ab, act, rxe, fe;
  logic [4:0] cc;
  logic [13:0] fb;
  int errorCnt = 0;
  int samplesChecked = 0;
  int seed = 32'h536A4753;
  int cnt[4] = '{0, 0, 0, 0};
  logic [3:0] stat = 4'h0;
  always #4 clk = ~clk;
  mac_error_statistics_counters dut_u (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rd),
    .wb_ack_o(ack), .wb_err_o(err), .txAbort(ab), .txCollisionCount(cc), .rxFrameActive(act),
    .phy_receive_error(rxe), .rxFrameEnd(fe), .rxFrameBytes(fb), .irq_r(irq));
  phy_line_model phy_u (.clk(clk), .ab(ab), .cc(cc), .act(act), .rxe(rxe), .fe(fe), .fb(fb));
  task automatic closeOut;
    $display("Mismatches %0d, comparisons %0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [32:0] q);
    @(posedge clk);
    adr <= {20'h0, a};
    we <= w;
    wd <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    repeat (50) begin
      @(posedge clk);
      if (ack || err) break;
    end
    if (!(ack || err)) begin
      errorCnt++;
      closeOut;
    end
    q = {err, rd};
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdChk(input logic [11:0] a, input int e);
    logic [32:0] q, x;
    x = e;
    bus(a, 1'b0, 32'h0, q);
    `CHK(q, x)
  endtask
  initial begin
    logic [32:0] q;
    logic [13:0] len;
    logic [4:0] col;
    logic bad;
    int bound;
    logic [13:0] lens [6] = '{14'h003F, 14'h0040, 14'h05EE, 14'h05EF, 14'h0600, 14'h0601};
    bound = 1518;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(12'h140, 1'b1, 32'h000003FF, q);
    bus(12'h198, 1'b1, 32'hFFFFFFFF, q);
    rdChk(12'h140, 0);
    rdChk(12'h198, 0);
    bus(12'h020, 1'b0, 32'h0, q);
    `CHK(q[32], 1'b1)
    for (int i = 0; i < 48; i++) begin
      if (i == 24) begin
        bus(12'h000, 1'b1, 32'h1, q);
        bound = 1536;
      end
      if ($random(seed) & 1) begin
        col = 5'h0F + ($random(seed) & 1);
        phy_u.abortTx(col);
        if (col == 5'h10) cnt[0]++;
        if (col == 5'h10) stat[0] = 1'b1;
      end else begin
        len = lens[($random(seed) & 32'hFF) % 6];
        bad = $random(seed);
        phy_u.recv(len, bad, $random(seed) & 7);
        if (bad) begin
          cnt[1]++;
          stat[1] = 1'b1;
          if (len >= 64 && len <= bound) cnt[2]++;
          if (len >= 64 && len <= bound) stat[2] = 1'b1;
          if (len > bound) cnt[3]++;
          if (len > bound) stat[3] = 1'b1;
        end
      end
      rdChk(12'h140, cnt[0]);
      rdChk(12'h198, cnt[1]);
      rdChk(12'h010, cnt[2]);
      rdChk(12'h014, cnt[3]);
    end
    bus(12'h140, 1'b1, 32'hFFFFFFFF, q);
    rdChk(12'h140, cnt[0]);
    `CHK(irq, 1'b0)
    bus(12'h008, 1'b1, 32'hF, q);
    repeat (2) @(posedge clk);
    `CHK(irq, |stat)
    rdChk(12'h004, stat);
    bus(12'h004, 1'b1, 32'hF, q);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    rdChk(12'h004, 0);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdChk(12'h140, 0);
    rdChk(12'h198, 0);
    closeOut;
  end
endmodule // mac_error_statistics_counters_tb
`default_nettype wire
